// *** include/mme_consts.vh ***
`ifndef MME_CONSTS_VH
`define MME_CONSTS_VH
`define MME_DATA_W 16
`define MME_CHK_W 6
`define MME_WORD_W 22
`define MME_ADDR_W 19
`define MME_BANK_W 3
`define MME_NUM_IOP 8
`define MME_CNT_W 17
`define MME_CNT_LIMIT 17'h10000
// group membership masks, one per check bit A..F
`define MME_GRP_A 16'h8c71
`define MME_GRP_B 16'h4ab1
`define MME_GRP_C 16'h29d2
`define MME_GRP_D 16'h1766
`define MME_GRP_E 16'hd31c
`define MME_GRP_F 16'h208f
`define MME_MOP_W 2
`define MME_MOP_NONE 2'h0
`endif

// *** core/mme_memory_ecc.v ***
`timescale 1ns/100ps
`include "mme_consts.vh"

module mme_memory_ecc #(
  parameter BANKS = 8
) (
  // clock and reset
  input wire clk,
  input wire rst,
  // arbitration
  input wire [`MME_NUM_IOP-1:0] iop_req,
  input wire [`MME_MOP_W-1:0] micro_memory_op_field,
  input wire refresh_req,
  output wire [`MME_NUM_IOP:0] grant,
  output wire refresh_grant,
  // memory bus request from granted processor
  input wire bus_we,
  input wire bus_byte,
  input wire [`MME_ADDR_W-1:0] bus_addr,
  input wire [`MME_DATA_W-1:0] bus_wdata,
  output wire addr_error,
  // storage array port
  output reg mem_we_q,
  output reg [`MME_ADDR_W-2:0] mem_addr_q,
  output reg [`MME_WORD_W-1:0] mem_wword_q,
  input wire [`MME_WORD_W-1:0] mem_rword,
  input wire mem_rvalid,
  // corrected read result
  input wire ecc_disable,
  output reg [`MME_DATA_W-1:0] rdata_q,
  output reg rvalid_q,
  output reg multi_bit_error_flag_q,
  output reg panel_lamp_q
);

  localparam [`MME_DATA_W-1:0] GA = `MME_GRP_A;
  localparam [`MME_DATA_W-1:0] GB = `MME_GRP_B;
  localparam [`MME_DATA_W-1:0] GC = `MME_GRP_C;
  localparam [`MME_DATA_W-1:0] GD = `MME_GRP_D;
  localparam [`MME_DATA_W-1:0] GE = `MME_GRP_E;
  localparam [`MME_DATA_W-1:0] GF = `MME_GRP_F;

  // odd parity per group; the same masks serve write and read
  function [`MME_CHK_W-1:0] chk_gen;
    input [`MME_DATA_W-1:0] d;
    begin
      chk_gen = {~^(d & GF), ~^(d & GE), ~^(d & GD), ~^(d & GC), ~^(d & GB), ~^(d & GA)};
    end
  endfunction

  // column of group membership for one data bit
  function [`MME_CHK_W-1:0] col;
    input integer i;
    begin
      col = {GF[i], GE[i], GD[i], GC[i], GB[i], GA[i]};
    end
  endfunction

  // membership mask of one check group, 0 is A and 5 is F
  function [`MME_DATA_W-1:0] grp_mask;
    input integer gi;
    begin
      case (gi)
        0: grp_mask = GA;
        1: grp_mask = GB;
        2: grp_mask = GC;
        3: grp_mask = GD;
        4: grp_mask = GE;
        5: grp_mask = GF;
        default: grp_mask = {`MME_DATA_W{1'b0}};
      endcase
    end
  endfunction

  // count of failing groups; a lone bad data bit fails three for nine of the sixteen bits, two or four for the rest
  function [2:0] fail_weight;
    input [`MME_CHK_W-1:0] f;
    integer j;
    begin
      fail_weight = 3'h0;
      for (j = 0; j < `MME_CHK_W; j = j + 1)
        fail_weight = fail_weight + {2'h0, f[j]};
    end
  endfunction

  // fixed priority: lowest request bit wins
  function [`MME_NUM_IOP:0] prio_pick;
    input [`MME_NUM_IOP-1:0] req;
    input cpu;
    integer s;
    reg found;
    begin
      prio_pick = {(`MME_NUM_IOP+1){1'b0}};
      found = 1'b0;
      for (s = 0; s < `MME_NUM_IOP; s = s + 1) begin
        if (req[s] && !found) begin
          prio_pick[s] = 1'b1;
          found = 1'b1;
        end
      end
      // cpu steals cycles only when every slot is idle
      if (!found && cpu)
        prio_pick[`MME_NUM_IOP] = 1'b1;
    end
  endfunction

  // read lane pick: even byte address is the high byte
  function [7:0] lane_pick;
    input [`MME_DATA_W-1:0] d;
    input hi;
    begin
      if (hi)
        lane_pick = d[15:8];
      else
        lane_pick = d[7:0];
    end
  endfunction

  // arbitration: refresh blocks everything, then slot 1 down to cpu
  wire cpu_req;
  reg [`MME_NUM_IOP:0] grant_c;

  assign cpu_req = (micro_memory_op_field != `MME_MOP_NONE);
  always @* begin
    if (refresh_req)
      grant_c = {(`MME_NUM_IOP+1){1'b0}};
    else
      grant_c = prio_pick(iop_req, cpu_req);
  end
  assign grant = grant_c;
  // one row is refreshed in every bank at once, so the array needs only this strobe
  assign refresh_grant = refresh_req;

  // address beyond installed banks is refused
  wire [`MME_BANK_W-1:0] bank;
  wire cyc;
  wire cyc_rd;
  wire cyc_wr;

  assign bank = bus_addr[`MME_ADDR_W-1:`MME_ADDR_W-`MME_BANK_W];
  assign addr_error = ({1'b0, bank} >= BANKS[`MME_BANK_W:0]);
  assign cyc = (grant_c != {(`MME_NUM_IOP+1){1'b0}}) && !addr_error;
  assign cyc_rd = cyc && !bus_we;
  assign cyc_wr = cyc && bus_we;

  // write path: check bits generated, data stored as is
  reg [`MME_DATA_W-1:0] wdata_c;
  reg mem_we_d;
  reg [`MME_ADDR_W-2:0] mem_addr_d;
  reg [`MME_WORD_W-1:0] mem_wword_d;

  always @* begin
    wdata_c = bus_wdata;
    if (bus_byte)
      wdata_c = {bus_wdata[7:0], bus_wdata[7:0]};
  end
  always @* begin
    mem_we_d = cyc_wr;
    mem_addr_d = bus_addr[`MME_ADDR_W-1:1];
    // byte writes store the full halfword with both lanes; no read-modify-write
    mem_wword_d = {chk_gen(wdata_c), wdata_c};
  end
  always @(posedge clk) begin
    if (rst) begin
      mem_we_q <= 1'b0;
      mem_addr_q <= {(`MME_ADDR_W-1){1'b0}};
      mem_wword_q <= {`MME_WORD_W{1'b0}};
    end else begin
      mem_we_q <= mem_we_d;
      mem_addr_q <= mem_addr_d;
      mem_wword_q <= mem_wword_d;
    end
  end

  // lane choice is held from the read request until its data returns
  reg byte_q;
  reg byte_d;
  reg hi_q;
  reg hi_d;

  always @* begin
    byte_d = byte_q;
    hi_d = hi_q;
    if (cyc_rd) begin
      byte_d = bus_byte;
      hi_d = ~bus_addr[0];
    end
  end
  always @(posedge clk) begin
    if (rst) begin
      byte_q <= 1'b0;
      hi_q <= 1'b0;
    end else begin
      byte_q <= byte_d;
      hi_q <= hi_d;
    end
  end

  // read stage 1: each check takes its group's six to eight data bits plus the stored bit
  wire [`MME_DATA_W-1:0] rd_data;
  wire [`MME_CHK_W-1:0] rd_chk;
  wire [`MME_CHK_W-1:0] rd_fail;

  // check bits sit above the data in the stored word
  assign rd_data = mem_rword[`MME_DATA_W-1:0];
  assign rd_chk = mem_rword[`MME_WORD_W-1:`MME_DATA_W];
  genvar gc;
  generate
    for (gc = 0; gc < `MME_CHK_W; gc = gc + 1) begin : g_chk
      // even parity over the group's data bits and its stored bit marks the group as failing
      assign rd_fail[gc] = ~^{rd_chk[gc], rd_data & grp_mask(gc)};
    end
  endgenerate

  reg [`MME_DATA_W-1:0] raw_q;
  reg [`MME_DATA_W-1:0] raw_d;
  reg [`MME_CHK_W-1:0] fail_q;
  reg [`MME_CHK_W-1:0] fail_d;
  reg st1_q;
  reg st1_d;

  always @* begin
    st1_d = mem_rvalid;
    raw_d = raw_q;
    fail_d = fail_q;
    if (mem_rvalid) begin
      raw_d = rd_data;
      fail_d = rd_fail;
    end
  end
  always @(posedge clk) begin
    if (rst) begin
      raw_q <= {`MME_DATA_W{1'b0}};
      fail_q <= {`MME_CHK_W{1'b0}};
      st1_q <= 1'b0;
    end else begin
      raw_q <= raw_d;
      fail_q <= fail_d;
      st1_q <= st1_d;
    end
  end

  // decode to one correction bit per data line
  wire [`MME_DATA_W-1:0] fix;
  wire [`MME_DATA_W-1:0] cor;
  reg single;
  reg multi;

  genvar g;
  generate
    for (g = 0; g < `MME_DATA_W; g = g + 1) begin : g_fix
      assign fix[g] = (fail_q == col(g));
    end
  endgenerate
  // a match must also have weight three; two-bit patterns can still alias, bits 11 and 13 decode as bit 0
  always @* begin
    single = 1'b0;
    multi = 1'b0;
    case (fail_weight(fail_q))
      3'h0: begin
        single = 1'b0;
        multi = 1'b0;
      end
      3'h3: begin
        single = (fix != {`MME_DATA_W{1'b0}});
        multi = (fix == {`MME_DATA_W{1'b0}});
      end
      default: begin
        single = 1'b0;
        multi = 1'b1;
      end
    endcase
  end
  assign cor = ecc_disable ? raw_q : (raw_q ^ fix);

  // output stage; storage never sees the corrected word
  reg [`MME_DATA_W-1:0] rdata_d;
  reg rvalid_d;

  always @* begin
    rvalid_d = st1_q;
    rdata_d = rdata_q;
    if (st1_q) begin
      if (byte_q)
        rdata_d = {8'h00, lane_pick(cor, hi_q)};
      else
        rdata_d = cor;
    end
  end
  always @(posedge clk) begin
    if (rst) begin
      rdata_q <= {`MME_DATA_W{1'b0}};
      rvalid_q <= 1'b0;
    end else begin
      rdata_q <= rdata_d;
      rvalid_q <= rvalid_d;
    end
  end

  // error flag pulses with the read result it belongs to
  reg multi_bit_error_flag_d;

  always @* begin
    multi_bit_error_flag_d = st1_q && multi && !ecc_disable;
  end
  always @(posedge clk) begin
    if (rst)
      multi_bit_error_flag_q <= 1'b0;
    else
      multi_bit_error_flag_q <= multi_bit_error_flag_d;
  end

  // counter saturates so the lamp cannot go dark by wrapping
  reg [`MME_CNT_W-1:0] cnt_q;
  reg [`MME_CNT_W-1:0] cnt_d;

  always @* begin
    cnt_d = cnt_q;
    if (st1_q && single && !ecc_disable && cnt_q != {`MME_CNT_W{1'b1}})
      cnt_d = cnt_q + {{(`MME_CNT_W-1){1'b0}}, 1'b1};
  end
  always @(posedge clk) begin
    if (rst)
      cnt_q <= {`MME_CNT_W{1'b0}};
    else
      cnt_q <= cnt_d;
  end

  // lamp is sticky; only reset puts it out
  reg panel_lamp_d;

  always @* begin
    panel_lamp_d = panel_lamp_q;
    if (cnt_q > `MME_CNT_LIMIT)
      panel_lamp_d = 1'b1;
  end
  always @(posedge clk) begin
    if (rst)
      panel_lamp_q <= 1'b0;
    else
      panel_lamp_q <= panel_lamp_d;
  end

endmodule

// *** tb/mme_memory_ecc_chk.sv ***
`timescale 1ns/100ps
module mme_memory_ecc_chk #(parameter BANKS = 8) (
  // arbitration
  input wire clk, input wire rst, input wire refresh_req, input wire refresh_grant,
  input wire [7:0] iop_req, input wire [1:0] micro_memory_op_field, input wire [8:0] grant,
  // address and read path
  input wire [18:0] bus_addr, input wire addr_error, input wire mem_rvalid, input wire rvalid_q,
  input wire multi_bit_error_flag_q, input wire panel_lamp_q
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  AST_REFRESH: assert property (refresh_req |-> grant == 9'h000 && refresh_grant)
    else $error("grant during refresh");
  AST_PRIO: assert property (!refresh_req && iop_req != 0 |-> grant == {1'b0, iop_req & -iop_req})
    else $error("wrong io grant");
  AST_CPU: assert property (!refresh_req && iop_req == 0 |-> grant[8] == (micro_memory_op_field != 0))
    else $error("wrong cpu grant");
  AST_ADDR: assert property (addr_error == (bus_addr[18:16] >= BANKS))
    else $error("wrong address error");
  AST_RLAT: assert property (mem_rvalid |-> ##2 rvalid_q)
    else $error("read result late");
  AST_RONLY: assert property (rvalid_q |-> $past(mem_rvalid, 2))
    else $error("read result without read");
  AST_FLAG: assert property (multi_bit_error_flag_q |-> rvalid_q)
    else $error("flag outside read");
  AST_LAMP: assert property (panel_lamp_q |=> panel_lamp_q)
    else $error("lamp dropped");
endmodule
bind mme_memory_ecc mme_memory_ecc_chk #(.BANKS(BANKS)) u_chk (.*);

// *** tb/mme_store_model.sv ***
`timescale 1ns/100ps
module mme_store_model (
  input wire clk, input wire we, input wire rd, input wire [17:0] addr,
  input wire [21:0] wword, input wire [21:0] flip,
  output reg [21:0] rword, output reg rvalid
);
  reg [21:0] mem [0:15];
  initial rword = 22'h0;
  always @(posedge clk) begin
    rvalid <= rd;
    if (we) mem[addr[3:0]] <= wword;
    // idle lines wander so stale data cannot pass
    rword <= rd ? mem[addr[3:0]] ^ flip : ~rword;
  end
endmodule

// *** tb/test_main_memory_ecc_and_access_priority.sv ***
`timescale 1ns/100ps
`include "mme_consts.vh"
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin error_cnt++; \
  $display("wrong value at %0t: %h expected %h", $time, a, b); end end
module test_main_memory_ecc_and_access_priority;
  logic clk = 0, rst = 1, refresh_req = 0, bus_we = 0, bus_byte = 0, ecc_disable = 0, rd = 0;
  logic [7:0] iop_req = 0;
  logic [1:0] micro_memory_op_field = 0;
  logic [18:0] bus_addr = 0;
  logic [15:0] bus_wdata = 0;
  logic [21:0] flip = 0;
  wire [21:0] mem_rword, mem_wword_q;
  wire [17:0] mem_addr_q;
  wire [15:0] rdata_q;
  wire [8:0] grant;
  wire mem_rvalid, refresh_grant, addr_error, mem_we_q, rvalid_q, multi_bit_error_flag_q, panel_lamp_q;
  int error_cnt = 0, tests_run = 0;
  int trap_cnt = 0;
  mme_memory_ecc #(.BANKS(4)) dut (.*);
  mme_store_model mdl (.clk(clk), .we(mem_we_q), .rd(rd), .addr(mem_addr_q), .wword(mem_wword_q),
    .flip(flip), .rword(mem_rword), .rvalid(mem_rvalid));
  initial forever #25 clk = ~clk;
  // central processor side: every flag pulse sends it to its error routine
  always @(posedge clk) if (multi_bit_error_flag_q) trap_cnt <= trap_cnt + 1;
  function automatic [5:0] cbits(input [15:0] d);
    cbits = {~^(d & `MME_GRP_F), ~^(d & `MME_GRP_E), ~^(d & `MME_GRP_D),
      ~^(d & `MME_GRP_C), ~^(d & `MME_GRP_B), ~^(d & `MME_GRP_A)};
  endfunction
  task results;
    $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // slot one cycle; caller stands on a rising edge
  task acc(input w, input b, input [18:0] a, input [15:0] d);
    iop_req <= 8'h01; bus_we <= w; bus_byte <= b; bus_addr <= a; bus_wdata <= d;
    @(posedge clk);
    iop_req <= 8'h00; bus_we <= 0; rd <= !w;
    #1 `CHK(mem_we_q, w)
    `CHK(mem_addr_q, a[18:1])
    if (w) `CHK(mem_wword_q, {cbits(d), d})
    @(posedge clk);
    rd <= 0;
  endtask
  task rdchk(input [21:0] f, input dis, input b, input [18:0] a, input [15:0] exp, input expf);
    flip <= f; ecc_disable <= dis;
    acc(0, b, a, 16'h0);
    #1;
    repeat (8) if (rvalid_q !== 1'b1) begin @(posedge clk); #1; end
    `CHK(rvalid_q, 1'b1)
    `CHK(multi_bit_error_flag_q, expf)
    if (!expf) `CHK(b ? {8'h00, rdata_q[7:0]} : rdata_q, exp)
    @(posedge clk);
  endtask
  task t_arb;
    for (int k = 0; k < 8; k++) begin
      @(posedge clk); iop_req <= 8'hff << k; micro_memory_op_field <= 2'h3;
      #1 `CHK(grant, 9'h001 << k)
    end
    for (int m = 0; m < 4; m++) begin
      @(posedge clk); iop_req <= 8'h00; micro_memory_op_field <= m[1:0];
      #1 `CHK(grant, {m != 0, 8'h00})
    end
    @(posedge clk); iop_req <= 8'h01; refresh_req <= 1;
    #1 `CHK({grant, refresh_grant}, 10'h001)
    @(posedge clk); iop_req <= 8'h00; refresh_req <= 0; bus_addr <= 19'h40000; micro_memory_op_field <= 2'h0;
    #1 `CHK(addr_error, 1'b1)
    `CHK(grant, 9'h000)
    $display("arbitration test done");
  endtask
  task t_ecc;
    @(posedge clk);
    acc(1, 0, 19'h00004, 16'hca26);
    rdchk(22'h0, 0, 0, 19'h4, 16'hca26, 0);
    rdchk(22'h100, 0, 0, 19'h4, 16'hca26, 0);
    rdchk(22'h300, 0, 0, 19'h4, 16'h0, 1);
    rdchk(22'h100, 1, 0, 19'h4, 16'hcb26, 0);
    rdchk(22'h0, 0, 1, 19'h4, 16'h00ca, 0);
    rdchk(22'h0, 0, 1, 19'h5, 16'h0026, 0);
    `CHK(trap_cnt, 1)
    `CHK(panel_lamp_q, 1'b0)
    $display("ecc test done");
  endtask
  initial begin
    repeat (2) @(posedge clk);
    rst <= 0;
    t_arb;
    t_ecc;
    results;
  end
  // whole run is under two hundred cycles
  initial begin
    #50000;
    error_cnt++;
    results;
  end
endmodule
